// File: core/rx_status_consts.svh
// Register offsets, port count, reset values and timing counts of the receive-port status bank
`ifndef RX_STATUS_CONSTS_SVH
`define RX_STATUS_CONSTS_SVH

`define NUM_RX_PORTS        4
`define PORT_SEL_W          2

`define ADDR_PORT_SEL       8'h4C
`define ADDR_FREQ_INTEGER   8'h4F
`define ADDR_FREQ_FRACTION  8'h50
`define ADDR_ALARM_FLAGS    8'h51
`define ADDR_VOLTAGE_LEVELS 8'h52
`define ADDR_TEMP_LEVEL     8'h53
`define ADDR_CSI_ERRORS     8'h54
`define ADDR_PARITY_HIGH    8'h55
`define ADDR_PARITY_LOW     8'h56

`define RESET_BYTE          8'h00
`define RESET_WORD          16'h0000
`define WORD_MAX            16'hFFFF

// Frequency window: edges counted over 256 us equal the rate in 1/256 MHz
`define CLK_RATE_MHZ        10
`define FREQ_WINDOW_US      256
`define FREQ_WINDOW_CYCLES  (`FREQ_WINDOW_US * `CLK_RATE_MHZ)
`define FREQ_WIN_CNT_W      12

`endif

// File: core/rx_status_pkg.sv
// Types shared by the receive-port status bank
package rx_status_pkg;

    typedef struct packed {
        logic       csi_alarm;
        logic       remote_backchannel_alarm;
        logic       link_detect_alarm;
        logic       temperature_alarm;
        logic       remote_voltage1_alarm;
        logic       remote_voltage0_alarm;
    } alarm_flags_t;

    typedef struct packed {
        logic       remote_double_bit_ecc_error;
        logic       remote_checksum_error;
        logic       remote_start_of_transmission_error;
        logic       remote_sync_error;
        logic       remote_control_error;
    } csi_errors_t;

    typedef struct packed {
        alarm_flags_t alarms;
        logic [2:0]   remote_voltage1_sample;
        logic [2:0]   remote_voltage0_sample;
        logic [2:0]   temperature_sample;
        csi_errors_t  csi_errors;
    } remote_status_t;

    typedef struct packed {
        logic [7:0] link_freq_integer_byte;
        logic [7:0] link_freq_fraction_byte;
    } link_freq_t;

endpackage : rx_status_pkg

// File: core/link_freq_meter.sv
// Measures one serial link's recovered clock rate as 8.8 fixed-point MHz
`timescale 1ns/1ps
`include "rx_status_consts.svh"

module link_freq_meter
    import rx_status_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Link clock pin, asynchronous to mclk
    input  wire logic       link_clk_pin,
    // Shared window strobe
    input  wire logic       window_end,
    // Measurement
    output link_freq_t      freq_ff
);

    logic       sync1_ff;
    logic       sync2_ff;
    logic       prev_ff;
    logic [15:0] edge_cnt_ff;
    logic       rise;

    // ************************************************
    // Pin synchroniser
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= link_clk_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;

    // ************************************************
    // Edge counting over the window
    // ************************************************
    // Saturates rather than wraps so an over-range link never reads as slow
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            edge_cnt_ff <= `RESET_WORD;
            freq_ff     <= `RESET_WORD;
        end else if (window_end) begin
            freq_ff     <= edge_cnt_ff;
            edge_cnt_ff <= {15'h0000, rise};
        end else if (rise && edge_cnt_ff != `WORD_MAX) begin
            edge_cnt_ff <= edge_cnt_ff + 16'h0001;
        end
    end

endmodule : link_freq_meter

// File: core/rx_port_remote_status_regs.sv
// Per-receive-port link frequency, remote serializer status and parity count registers
//
// How it works
// - Measure each link's frequency, two read-only bytes
// - Low byte: fraction in 1/256 MHz, reset zero
// - High byte: integer MHz of same measurement
// - Reads return copy of port at 0x4C
// - Sensor status loaded from forward channel automatically
// - Load only when partner is compatible type
// - Status 0: six alarm flags, 7:6 reserved
// - Status 1: voltage samples at 6:4, 2:0
// - Status 2: temperature sample 2:0, rest zero
// - Status 3: five CSI-2 error flags, 7:5 reserved
// - Status fields read-only, reset to zero
// - Parity high byte cleared by low-byte read
`timescale 1ns/1ps
`include "rx_status_consts.svh"

module rx_port_remote_status_regs
    import rx_status_pkg::*;
(
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // Register access from the I2C target
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    output logic [7:0]                         reg_rdata_ff,
    output logic                               reg_rvalid_ff,
    // Link side, one entry per receive port
    input  wire logic [`NUM_RX_PORTS-1:0]      link_clk_pin,
    input  wire logic [`NUM_RX_PORTS-1:0]      status_valid,
    input  remote_status_t                     status_word [`NUM_RX_PORTS],
    input  wire logic [`NUM_RX_PORTS-1:0]      partner_compatible,
    input  wire logic [`NUM_RX_PORTS-1:0]      parity_error
);

    logic [`PORT_SEL_W-1:0]     port_sel_ff;
    logic [`FREQ_WIN_CNT_W-1:0] win_cnt_ff;
    logic                       window_end;
    link_freq_t                 freq         [`NUM_RX_PORTS];
    alarm_flags_t               alarm_ff     [`NUM_RX_PORTS];
    logic [2:0]                 volt1_ff     [`NUM_RX_PORTS];
    logic [2:0]                 volt0_ff     [`NUM_RX_PORTS];
    logic [2:0]                 temp_ff      [`NUM_RX_PORTS];
    csi_errors_t                csi_err_ff   [`NUM_RX_PORTS];
    logic [15:0]                parity_cnt_ff[`NUM_RX_PORTS];
    logic [`NUM_RX_PORTS-1:0]   status_load;
    logic [`NUM_RX_PORTS-1:0]   parity_clear;
    logic                       low_read;
    link_freq_t                 sel_freq;
    logic [15:0]                sel_parity;
    logic [7:0]                 port_sel_byte;
    logic [7:0]                 alarm_byte;
    logic [7:0]                 voltage_byte;
    logic [7:0]                 temperature_byte;
    logic [7:0]                 csi_error_byte;
    logic [7:0]                 nxt_rdata;

    localparam logic [`FREQ_WIN_CNT_W-1:0] WIN_LAST =
        `FREQ_WIN_CNT_W'(`FREQ_WINDOW_CYCLES - 1);

    // ************************************************
    // Port select
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port_sel_ff <= '0;
        end else if (reg_wr && reg_addr == `ADDR_PORT_SEL) begin
            port_sel_ff <= reg_wdata[`PORT_SEL_W-1:0];
        end
    end

    // ************************************************
    // Measurement window shared by all ports
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            win_cnt_ff <= '0;
        end else if (window_end) begin
            win_cnt_ff <= '0;
        end else begin
            win_cnt_ff <= win_cnt_ff + 1'b1;
        end
    end

    assign window_end = (win_cnt_ff == WIN_LAST);
    assign low_read   = reg_rd && reg_addr == `ADDR_PARITY_LOW;

    // ************************************************
    // Per-port state
    // ************************************************
    for (genvar p = 0; p < `NUM_RX_PORTS; p++) begin : g_port
        link_freq_meter u_meter (
            .mclk         (mclk),
            .rst_n        (rst_n),
            .link_clk_pin (link_clk_pin[p]),
            .window_end   (window_end),
            .freq_ff      (freq[p])
        );

        // Older partners send no status word; fields keep their last value
        assign status_load[p]  = status_valid[p] && partner_compatible[p];
        // Only the selected port's count is cleared by a low-byte read
        assign parity_clear[p] = low_read && port_sel_ff == `PORT_SEL_W'(p);

        // Each field keeps its last forwarded value between status words
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                alarm_ff[p] <= '0;
            end else if (status_load[p]) begin
                alarm_ff[p] <= status_word[p].alarms;
            end
        end

        // Both sensor samples arrive in one word and update together
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                volt1_ff[p] <= '0;
                volt0_ff[p] <= '0;
            end else if (status_load[p]) begin
                volt1_ff[p] <= status_word[p].remote_voltage1_sample;
                volt0_ff[p] <= status_word[p].remote_voltage0_sample;
            end
        end

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                temp_ff[p] <= '0;
            end else if (status_load[p]) begin
                temp_ff[p] <= status_word[p].temperature_sample;
            end
        end

        // Error flags are a snapshot, not sticky: a clean word clears them
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                csi_err_ff[p] <= '0;
            end else if (status_load[p]) begin
                csi_err_ff[p] <= status_word[p].csi_errors;
            end
        end

        // Count is kept whole; a pulse in the clearing cycle counts as one
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                parity_cnt_ff[p] <= `RESET_WORD;
            end else if (parity_clear[p]) begin
                parity_cnt_ff[p] <= {15'h0000, parity_error[p]};
            end else if (parity_error[p] && parity_cnt_ff[p] != `WORD_MAX) begin
                parity_cnt_ff[p] <= parity_cnt_ff[p] + 16'h0001;
            end
        end
    end

    // ************************************************
    // Read mux
    // ************************************************
    // One select index serves every register, so all bytes come from one port
    assign sel_freq   = freq[port_sel_ff];
    assign sel_parity = parity_cnt_ff[port_sel_ff];

    // Reserved bits are tied low here, so no field can leak into them
    assign port_sel_byte    = {{(8-`PORT_SEL_W){1'b0}}, port_sel_ff};
    assign alarm_byte       = {2'b00, alarm_ff[port_sel_ff]};
    assign voltage_byte     = {1'b0, volt1_ff[port_sel_ff],
                               1'b0, volt0_ff[port_sel_ff]};
    assign temperature_byte = {5'h00, temp_ff[port_sel_ff]};
    assign csi_error_byte   = {3'h0, csi_err_ff[port_sel_ff]};

    // ************************************************
    // Read decode
    // ************************************************
    // Unmapped offsets read as zero
    always_comb begin
        nxt_rdata = `RESET_BYTE;
        if (reg_addr == `ADDR_PORT_SEL) begin
            nxt_rdata = port_sel_byte;
        end else if (reg_addr == `ADDR_FREQ_INTEGER) begin
            nxt_rdata = sel_freq.link_freq_integer_byte;
        end else if (reg_addr == `ADDR_FREQ_FRACTION) begin
            nxt_rdata = sel_freq.link_freq_fraction_byte;
        end else if (reg_addr == `ADDR_ALARM_FLAGS) begin
            nxt_rdata = alarm_byte;
        end else if (reg_addr == `ADDR_VOLTAGE_LEVELS) begin
            nxt_rdata = voltage_byte;
        end else if (reg_addr == `ADDR_TEMP_LEVEL) begin
            nxt_rdata = temperature_byte;
        end else if (reg_addr == `ADDR_CSI_ERRORS) begin
            nxt_rdata = csi_error_byte;
        end else if (reg_addr == `ADDR_PARITY_HIGH) begin
            nxt_rdata = sel_parity[15:8];
        end else if (reg_addr == `ADDR_PARITY_LOW) begin
            nxt_rdata = sel_parity[7:0];
        end
    end

    // ************************************************
    // Read response
    // ************************************************
    // Valid is a one-cycle answer to each read strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
        end
    end

    // Data holds between reads; writes to read-only offsets are ignored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_ff <= `RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule : rx_port_remote_status_regs

// File: test/status_monitor.sv
// Assertion checker for the status register read port
`timescale 1ns/1ps
module status_monitor (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Register port
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic       reg_rvalid_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ****
    // Read checks
    // ****
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid_ff)
        else $error("read not answered");
    a_pulse_only: assert property (!reg_rd |=> !reg_rvalid_ff)
        else $error("stray read valid");
    a_data_holds: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved");
    a_alarm_reserved: assert property (rd_at(8'h51) |=> reg_rdata_ff[7:6] == 2'h0)
        else $error("alarm reserved set");
    a_volt_reserved: assert property (rd_at(8'h52) |=> (reg_rdata_ff & 8'h88) == 8'h00)
        else $error("voltage reserved set");
    a_temp_reserved: assert property (rd_at(8'h53) |=> reg_rdata_ff[7:3] == 5'h00)
        else $error("temperature reserved set");
    a_csi_reserved: assert property (rd_at(8'h54) |=> reg_rdata_ff[7:5] == 3'h0)
        else $error("error reserved set");
    a_select_width: assert property (rd_at(8'h4C) |=> reg_rdata_ff[7:2] == 6'h00)
        else $error("select upper bits set");
endmodule : status_monitor

bind rx_port_remote_status_regs status_monitor u_mon (.mclk(mclk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff));

// File: test/serializer_model.sv
// Behavioural remote serializer on the link side of every port
`timescale 1ns/1ps
`include "rx_status_consts.svh"
module serializer_model
    import rx_status_pkg::*;
(
    // Clock
    input  wire logic                mclk,
    // Link side
    output logic [`NUM_RX_PORTS-1:0] link_clk_pin,
    output logic [`NUM_RX_PORTS-1:0] status_valid,
    output remote_status_t           status_word [`NUM_RX_PORTS],
    output logic [`NUM_RX_PORTS-1:0] partner_compatible,
    output logic [`NUM_RX_PORTS-1:0] parity_error
);
    initial begin
        link_clk_pin = '0;
        status_valid = '0;
        partner_compatible = '1;
        parity_error = '0;
        foreach (status_word[i]) status_word[i] = '0;
    end
    // ****
    // Link behaviour
    // ****
    // Locked link runs free at 2.5 MHz, edges clear of mclk rising edges
    always #200 link_clk_pin = ~link_clk_pin;
    task automatic send(input int p, input remote_status_t w, input logic c);
        @(posedge mclk) #1;
        status_word[p] = w;
        partner_compatible[p] = c;
        status_valid[p] = 1'b1;
        @(posedge mclk) #1;
        status_valid[p] = 1'b0;
        // Released word shows junk so a stale copy cannot pass
        status_word[p] = ~w;
    endtask : send
    task automatic par(input int p, input int n);
        repeat (n) begin
            @(posedge mclk) #1 parity_error[p] = 1'b1;
            @(posedge mclk) #1 parity_error[p] = 1'b0;
        end
    endtask : par
endmodule : serializer_model

// File: test/tb_top.sv
// Self-checking bench for the receive-port status register bank
`timescale 1ns/1ps
`include "rx_status_consts.svh"
module tb_top
    import rx_status_pkg::*;
;
    logic           mclk = 1'b0;
    logic           rst_n = 1'b0;
    logic           reg_wr = 1'b0;
    logic           reg_rd = 1'b0;
    logic [7:0]     reg_addr = 8'h00;
    logic [7:0]     reg_wdata = 8'h00;
    logic [7:0]     reg_rdata_ff;
    logic           reg_rvalid_ff;
    logic [3:0]     link_clk_pin, status_valid, partner_compatible, parity_error;
    remote_status_t status_word [`NUM_RX_PORTS];
    remote_status_t w1 = {6'h35, 3'h5, 3'h2, 3'h6, 5'h13};
    int             bad_count = 0;
    int             comparisons = 0;
    int             cycles = 0;
    always #50 mclk = ~mclk;
    rx_port_remote_status_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .link_clk_pin(link_clk_pin), .status_valid(status_valid),
        .status_word(status_word), .partner_compatible(partner_compatible),
        .parity_error(parity_error));
    serializer_model partner (.mclk(mclk), .link_clk_pin(link_clk_pin),
        .status_valid(status_valid), .status_word(status_word),
        .partner_compatible(partner_compatible), .parity_error(parity_error));
    // ****
    // Access tasks
    // ****
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        chk({7'h00, reg_rvalid_ff}, 8'h01);
        chk(reg_rdata_ff, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
    endtask : wr
    // Whole run needs about 5780 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        rd(8'h4F, 8'h00);
        rd(8'h50, 8'h00);
        for (int a = 8'h51; a <= 8'h55; a++) rd(a[7:0], 8'h00);
        rd(8'h60, 8'h00);
        partner.send(1, w1, 1'b1);
        wr(8'h51, 8'hFF);
        wr(8'h4C, 8'hFD);
        rd(8'h4C, 8'h01);
        rd(8'h51, 8'h35);
        rd(8'h52, 8'h52);
        rd(8'h53, 8'h06);
        rd(8'h54, 8'h13);
        partner.send(1, ~w1, 1'b0);
        rd(8'h51, 8'h35);
        wr(8'h4C, 8'h00);
        rd(8'h51, 8'h00);
        // Count of 259 reaches the upper byte
        partner.par(2, 259);
        wr(8'h4C, 8'h02);
        rd(8'h55, 8'h01);
        rd(8'h56, 8'h03);
        rd(8'h55, 8'h00);
        // Two full 2560-cycle windows so a settled value is held
        repeat (5200) @(posedge mclk);
        wr(8'h4C, 8'h03);
        rd(8'h4F, 8'h02);
        rd(8'h50, 8'h80);
        close_out();
    end
endmodule : tb_top
